// ==== rtl/lpc_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing codes for the
//          low-power calibration sleep/wake block.
// Assumes: 16-bit register address, 8-bit register data.
// Notes:   Included by its bare name; definitions only.
//
// Behaviour
// - The control register sits at offset 0x06e and resets to 0x88.
// - Bits 7..5 pick the sleep time (2^N+1)*256 clocks, N from 3 to 33.
// - Bits 4..3 pick the wake settle time, N = 3, 18, 21 or 24.
// - With trigger mode 0 and low power on, the sleep timer ends sleep.
// - With trigger mode 1, a sleeping core ignores the timer; the trigger or low power off wakes it.
// - The trigger is the software bit (select 0) or external pin (1).
// - Cycling happens only while background calibration is enabled.
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define LPC_ADDR_W          16
`define LPC_CTRL_OFFSET     16'h006e
`define LPC_STAT_OFFSET     16'h006f
`define LPC_CTRL_RST        8'h88

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LPC_LOW_POWER_CAL_ENABLE_BIT       0
`define LPC_TRIG_MODE_BIT   1
`define LPC_RSVD_BIT        2
`define LPC_WAKE_LSB        3
`define LPC_SLEEP_LSB       5

// ----------------------------------------------------------------------
// Timing: delay = (2^N + 1) * unit device-clock periods
// ----------------------------------------------------------------------
`define LPC_UNIT_CYCLES     256
`define LPC_EXP_MAX         33
`define LPC_SLP_EXP0        6'd3
`define LPC_SLP_EXP1        6'd15
`define LPC_SLP_EXP2        6'd18
`define LPC_SLP_EXP3        6'd21
`define LPC_SLP_EXP4        6'd24
`define LPC_SLP_EXP5        6'd27
`define LPC_SLP_EXP6        6'd30
`define LPC_SLP_EXP7        6'd33
`define LPC_WAKE_EXP0       6'd3
`define LPC_WAKE_EXP1       6'd18
`define LPC_WAKE_EXP2       6'd21
`define LPC_WAKE_EXP3       6'd24
`define LPC_CNT_W           48

`endif

// ==== rtl/lpc_pkg.sv ====
// Purpose: Types for the low-power calibration sleep/wake block.
// Assumes: Constants come from lpc_defs.svh.
// Notes:   Control register layout is a packed struct, MSB first.
package lpc_pkg;

    typedef struct packed {
        logic [2:0] sleep_sel;
        logic [1:0] wake_sel;
        logic       rsvd;
        logic       trig_mode;
        logic       low_power_cal_enable;
    } lpc_ctrl_t;

    typedef enum logic [3:0] {
        LPC_OFF    = 4'h1,
        LPC_CAL    = 4'h2,
        LPC_SLEEP  = 4'h4,
        LPC_SETTLE = 4'h8
    } lpc_state_t;

    typedef struct packed {
        lpc_ctrl_t  ctrl;
        lpc_state_t st;
        logic       active_core;
        logic [1:0] core_sleep;
        logic       cal_run;
        logic [7:0] rd_data;
        logic       trig_s1;
        logic       trig_s2;
    } lpc_top_st_t;

    typedef struct packed {
        logic [47:0] cnt;
        logic        busy;
        logic        done;
    } lpc_tmr_st_t;

endpackage

// ==== rtl/lpc_delay_timer.sv ====
// Purpose: One-shot delay of (2^exp + 1) * unit clocks.
// Assumes: Start and clear come from logic on the same clock.
// Notes:   A new start reloads the count even while busy.
`timescale 1ns/100ps
`include "lpc_defs.svh"

module lpc_delay_timer #(
    parameter int unsigned UNIT_CYCLES = `LPC_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Control
    input  wire logic       start,
    input  wire logic       clear,
    input  wire logic [5:0] exp_sel,
    // Status
    output logic            busy,
    output logic            done
);

    lpc_pkg::lpc_tmr_st_t q_reg;
    lpc_pkg::lpc_tmr_st_t q_next;
    logic [63:0]          load_full;

    // Exponent and unit are small, so the product stays under 64 bits
    assign load_full = ((64'd1 << exp_sel) + 64'd1) * 64'(UNIT_CYCLES);

    always_comb begin
        q_next      = q_reg;
        q_next.done = 1'b0;
        if (clear) begin
            q_next.busy = 1'b0;
        end else if (start) begin
            q_next.cnt  = load_full[47:0];
            q_next.busy = 1'b1;
        end else if (q_reg.busy) begin
            q_next.cnt = q_reg.cnt - 48'd1;
            if (q_reg.cnt == 48'd1) begin
                q_next.busy = 1'b0;
                q_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign busy = q_reg.busy;
    assign done = q_reg.done;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [47:0] elapsed_dbg;
    logic [47:0] expect_dbg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            elapsed_dbg <= '0;
            expect_dbg  <= '0;
        end else if (start) begin
            elapsed_dbg <= '0;
            expect_dbg  <= load_full[47:0];
        end else begin
            elapsed_dbg <= elapsed_dbg + 48'd1;
        end
    end

    a_done_count: assert property (@(posedge sys_clk) disable iff (srst)
        done |-> elapsed_dbg == expect_dbg)
        else $error("delay done at wrong cycle count");

endmodule

// ==== rtl/lpc_sleep_wake.sv ====
// Purpose: Low-power background calibration control register and core
//          sleep/wake sequencer for a two-core converter.
// Assumes: sys_clk is the device sample clock; register port and trigger
//          select inputs are on that clock; external trigger is a pin.
// Notes:   Delay parameters may be shrunk for simulation.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "lpc_defs.svh"

module lpc_sleep_wake #(
    parameter int unsigned UNIT_CYCLES = `LPC_UNIT_CYCLES,
    parameter int unsigned EXP_LIMIT   = `LPC_EXP_MAX
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // Neighbouring calibration settings
    input  wire logic        background_cal_enable,
    input  wire logic        cal_trigger_source_sel,
    input  wire logic        software_cal_trigger,
    // Trigger pin
    input  wire logic        external_cal_trigger_in,
    // Core control
    output logic [1:0]       core_sleep,
    output logic             cal_run,
    output logic             cal_core_sel
);

    lpc_pkg::lpc_top_st_t q_reg;
    lpc_pkg::lpc_top_st_t q_next;

    logic       trig_active;
    logic       tmr_start;
    logic       tmr_busy;
    logic       tmr_done;
    logic [5:0] tmr_exp;
    logic [5:0] sleep_exp;
    logic [5:0] wake_exp;
    logic [5:0] exp_cap;
    logic [7:0] status_byte;

    assign exp_cap = 6'(EXP_LIMIT);

    // ------------------------------------------------------------------
    // Delay code decode
    // ------------------------------------------------------------------
    // sleep code table
    always_comb begin
        unique case (q_reg.ctrl.sleep_sel)
            3'h0: sleep_exp = `LPC_SLP_EXP0;
            3'h1: sleep_exp = `LPC_SLP_EXP1;
            3'h2: sleep_exp = `LPC_SLP_EXP2;
            3'h3: sleep_exp = `LPC_SLP_EXP3;
            3'h4: sleep_exp = `LPC_SLP_EXP4;
            3'h5: sleep_exp = `LPC_SLP_EXP5;
            3'h6: sleep_exp = `LPC_SLP_EXP6;
            3'h7: sleep_exp = `LPC_SLP_EXP7;
        endcase
    end

    // wake settle table
    // Code 0 is honoured as written; software must avoid it
    always_comb begin
        unique case (q_reg.ctrl.wake_sel)
            2'h0: wake_exp = `LPC_WAKE_EXP0;
            2'h1: wake_exp = `LPC_WAKE_EXP1;
            2'h2: wake_exp = `LPC_WAKE_EXP2;
            2'h3: wake_exp = `LPC_WAKE_EXP3;
        endcase
    end

    assign trig_active = cal_trigger_source_sel ? q_reg.trig_s2
                                                : software_cal_trigger;

    assign status_byte = {q_reg.st, q_reg.active_core, q_reg.core_sleep,
                          q_reg.cal_run};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        q_next         = q_reg;
        tmr_start      = 1'b0;
        tmr_exp        = sleep_exp;
        q_next.trig_s1 = external_cal_trigger_in;
        q_next.trig_s2 = q_reg.trig_s1;

        // Read data valid for one cycle only
        q_next.rd_data = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `LPC_CTRL_OFFSET) begin
                q_next.rd_data = q_reg.ctrl;
            end else if (reg_addr == `LPC_STAT_OFFSET) begin
                q_next.rd_data = status_byte;
            end
        end
        if (reg_wr && reg_addr == `LPC_CTRL_OFFSET) begin
            q_next.ctrl = reg_wdata;
        end

        unique case (q_reg.st)
            lpc_pkg::LPC_OFF: begin
                q_next.core_sleep = 2'b00;
                q_next.cal_run    = 1'b0;
                if (background_cal_enable) begin
                    q_next.st      = lpc_pkg::LPC_CAL;
                    q_next.cal_run = 1'b1;
                end
            end
            lpc_pkg::LPC_CAL: begin
                if (!background_cal_enable) begin
                    q_next.st      = lpc_pkg::LPC_OFF;
                    q_next.cal_run = 1'b0;
                end else if (q_reg.ctrl.low_power_cal_enable) begin
                    q_next.st = lpc_pkg::LPC_SLEEP;
                    q_next.core_sleep[~q_reg.active_core] = 1'b1;
                    tmr_start = !q_reg.ctrl.trig_mode;
                end
            end
            lpc_pkg::LPC_SLEEP: begin
                if (!background_cal_enable) begin
                    q_next.st         = lpc_pkg::LPC_OFF;
                    q_next.core_sleep = 2'b00;
                    q_next.cal_run    = 1'b0;
                end else if (!q_reg.ctrl.low_power_cal_enable ||
                             (q_reg.ctrl.trig_mode ? trig_active
                                                   : tmr_done)) begin
                    q_next.st         = lpc_pkg::LPC_SETTLE;
                    q_next.core_sleep = 2'b00;
                    q_next.cal_run    = 1'b0;
                    tmr_start         = 1'b1;
                    tmr_exp           = wake_exp;
                end else if (!q_reg.ctrl.trig_mode && !tmr_busy) begin
                    // Mode switched to timed while asleep: arm the timer
                    tmr_start = 1'b1;
                end
            end
            lpc_pkg::LPC_SETTLE: begin
                if (!background_cal_enable) begin
                    q_next.st = lpc_pkg::LPC_OFF;
                end else if (tmr_done) begin
                    // Rotate calibration onto the rested core
                    q_next.st          = lpc_pkg::LPC_CAL;
                    q_next.active_core = ~q_reg.active_core;
                    q_next.cal_run     = 1'b1;
                end
            end
        endcase

        // restart on core 0 once calibration stops
        if (!background_cal_enable) begin
            q_next.active_core = 1'b0;
        end

        if (tmr_exp > exp_cap) begin
            tmr_exp = exp_cap;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_reg      <= '0;
            q_reg.ctrl <= `LPC_CTRL_RST;
            q_reg.st   <= lpc_pkg::LPC_OFF;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------------
    // Delay timer shared by sleep and settle phases
    // ------------------------------------------------------------------
    lpc_delay_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .srst    (srst),
        .start   (tmr_start),
        .clear   (q_reg.st == lpc_pkg::LPC_OFF),
        .exp_sel (tmr_exp),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    assign reg_rdata    = q_reg.rd_data;
    assign core_sleep   = q_reg.core_sleep;
    assign cal_run      = q_reg.cal_run;
    assign cal_core_sel = q_reg.active_core;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [5:0] ld_exp_dbg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ld_exp_dbg <= '0;
        end else if (tmr_start) begin
            ld_exp_dbg <= tmr_exp;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_reset_value: assert property (
        $fell(srst) |-> q_reg.ctrl == `LPC_CTRL_RST)
        else $error("control register not at reset value");

    a_sleep_load: assert property (
        ($rose(q_reg.st == lpc_pkg::LPC_SLEEP) && !$past(q_reg.ctrl.trig_mode))
        |-> ld_exp_dbg == (($past(sleep_exp) > exp_cap) ? exp_cap
                                                        : $past(sleep_exp)))
        else $error("sleep timer loaded with wrong exponent");

    a_settle_load: assert property (
        $rose(q_reg.st == lpc_pkg::LPC_SETTLE)
        |-> ld_exp_dbg == (($past(wake_exp) > exp_cap) ? exp_cap
                                                       : $past(wake_exp)))
        else $error("settle timer loaded with wrong exponent");

    a_timed_wake: assert property (
        (q_reg.st == lpc_pkg::LPC_SLEEP && !q_reg.ctrl.trig_mode &&
         q_reg.ctrl.low_power_cal_enable && background_cal_enable && tmr_done)
        |=> q_reg.st == lpc_pkg::LPC_SETTLE && core_sleep == 2'b00)
        else $error("timed sleep did not end");

    a_trig_hold: assert property (
        (q_reg.st == lpc_pkg::LPC_SLEEP && q_reg.ctrl.trig_mode &&
         q_reg.ctrl.low_power_cal_enable && background_cal_enable && !trig_active)
        |=> q_reg.st == lpc_pkg::LPC_SLEEP && core_sleep != 2'b00)
        else $error("core woke without trigger");

    a_lp_gate: assert property (
        $rose(core_sleep != 2'b00) |-> $past(q_reg.ctrl.low_power_cal_enable))
        else $error("core slept with low power disabled");

    a_soft_trig: assert property (
        (q_reg.st == lpc_pkg::LPC_SLEEP && q_reg.ctrl.trig_mode &&
         q_reg.ctrl.low_power_cal_enable && background_cal_enable &&
         !cal_trigger_source_sel && software_cal_trigger)
        |=> q_reg.st == lpc_pkg::LPC_SETTLE)
        else $error("software trigger did not wake core");

    a_bg_gate: assert property (
        !background_cal_enable |=> !cal_run && core_sleep == 2'b00)
        else $error("activity while background calibration off");

    a_off_state: assert property (
        !background_cal_enable
        |=> q_reg.st == lpc_pkg::LPC_OFF && !cal_core_sel)
        else $error("sequencer not idle on core 0 while disabled");

    a_rotate_core: assert property (
        (q_reg.st == lpc_pkg::LPC_SETTLE && background_cal_enable &&
         tmr_done)
        |=> cal_run && cal_core_sel != $past(cal_core_sel))
        else $error("calibration did not move to the rested core");

    a_settle_hold: assert property (
        (q_reg.st == lpc_pkg::LPC_SETTLE && background_cal_enable &&
         !tmr_done)
        |=> q_reg.st == lpc_pkg::LPC_SETTLE && !cal_run)
        else $error("calibration resumed before settle time");

    a_ext_trig: assert property (
        (q_reg.st == lpc_pkg::LPC_SLEEP && q_reg.ctrl.trig_mode &&
         q_reg.ctrl.low_power_cal_enable && background_cal_enable &&
         cal_trigger_source_sel && q_reg.trig_s2)
        |=> q_reg.st == lpc_pkg::LPC_SETTLE)
        else $error("external trigger did not wake core");

    // ------------------------------------------------------------------
    // Register port checks
    // ------------------------------------------------------------------
    a_write_lands: assert property (
        (reg_wr && reg_addr == `LPC_CTRL_OFFSET)
        |=> q_reg.ctrl == $past(reg_wdata))
        else $error("control write did not land");

    a_write_ignored: assert property (
        (reg_wr && reg_addr != `LPC_CTRL_OFFSET) |=> $stable(q_reg.ctrl))
        else $error("write to another offset changed control");

    a_read_back: assert property (
        (reg_rd && reg_addr == `LPC_CTRL_OFFSET)
        |=> reg_rdata == $past(q_reg.ctrl))
        else $error("control read returned wrong data");

    // Read data stands one cycle so a stale byte is never mistaken
    a_read_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");

    c_sleep_entry: cover property ($rose(core_sleep != 2'b00));
    c_rotate:      cover property ($changed(cal_core_sel));
    c_trig_wake:   cover property (
        q_reg.st == lpc_pkg::LPC_SLEEP && q_reg.ctrl.trig_mode
        ##1 q_reg.st == lpc_pkg::LPC_SETTLE);
    c_timed_wake:  cover property (
        q_reg.st == lpc_pkg::LPC_SLEEP && !q_reg.ctrl.trig_mode
        ##1 q_reg.st == lpc_pkg::LPC_SETTLE);

endmodule

// ==== verification/tb_lpc_sleep_wake.sv ====
// Purpose: Self-checking bench for the low-power sleep/wake sequencer.
// Assumes: Delays shortened with UNIT_CYCLES=1 and EXP_LIMIT=6.
// Notes:   Delay checks allow two cycles of pipeline slack.
`timescale 1ns/100ps
`include "lpc_defs.svh"

module tb_lpc_sleep_wake;
    localparam int UNIT = 1;
    localparam int ELIM = 6;

    logic        sys_clk;
    logic        srst;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        bg_en;
    logic        src_sel;
    logic        sw_trig;
    logic        ext_trig;
    logic [1:0]  core_sleep;
    logic        cal_run;
    logic        cal_core_sel;
    logic [7:0]  d;
    int          failures;
    int          n_compared;
    int          slp_e [8];
    int          wk_e [4];

    lpc_sleep_wake #(.UNIT_CYCLES(UNIT), .EXP_LIMIT(ELIM)) dut (
        .sys_clk                 (sys_clk),
        .srst                    (srst),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_rdata               (reg_rdata),
        .background_cal_enable   (bg_en),
        .cal_trigger_source_sel  (src_sel),
        .software_cal_trigger    (sw_trig),
        .external_cal_trigger_in (ext_trig),
        .core_sleep              (core_sleep),
        .cal_run                 (cal_run),
        .cal_core_sel            (cal_core_sel)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Checks and verdict
    // ------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic print_verdict;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Register port and waits
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    // Bounded so a stuck sequencer cannot hang the run
    task automatic count_sleep(input logic want, output int n);
        n = 0;
        while (((core_sleep !== 2'b00) == want) && n < 2000) begin
            tick;
            n++;
        end
    endtask

    task automatic count_idle(output int n);
        n = 0;
        while (cal_run !== 1'b1 && n < 2000) begin
            tick;
            n++;
        end
    endtask

    // Via OFF so every run starts with core 0 calibrating
    task automatic restart(input logic [7:0] c);
        @(posedge sys_clk);
        bg_en <= 1'b0;
        reg_write(16'h006e, c);
        @(posedge sys_clk);
        bg_en <= 1'b1;
    endtask

    task automatic timed_cycle(input logic [7:0] c);
        int n;
        int es;
        int ew;
        es = slp_e[c[7:5]] > ELIM ? ELIM : slp_e[c[7:5]];
        ew = wk_e[c[4:3]] > ELIM ? ELIM : wk_e[c[4:3]];
        restart(c);
        count_sleep(1'b0, n);
        chkn(n, 1, 3);
        chk8({6'h00, core_sleep}, 8'h02);
        count_sleep(1'b1, n);
        chkn(n, ((1 << es) + 1) * UNIT, ((1 << es) + 1) * UNIT + 2);
        count_idle(n);
        chkn(n, ((1 << ew) + 1) * UNIT, ((1 << ew) + 1) * UNIT + 2);
        chk8({7'h00, cal_core_sel}, 8'h01);
    endtask

    // Chosen source held low, the ignored one held high
    task automatic trig_cycle(input logic sel);
        int n;
        @(posedge sys_clk);
        src_sel <= sel;
        sw_trig <= sel;
        ext_trig <= ~sel;
        restart(8'h0b);
        count_sleep(1'b0, n);
        repeat (100) tick;
        chk8({6'h00, core_sleep}, 8'h02);
        reg_read(16'h006f, d);
        chk8(d, 8'h45);
        @(posedge sys_clk);
        if (sel) begin
            ext_trig <= 1'b1;
        end else begin
            sw_trig <= 1'b1;
        end
        count_sleep(1'b1, n);
        chkn(n, 0, 5);
        @(posedge sys_clk);
        sw_trig <= 1'b0;
        ext_trig <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bg_en = 1'b0;
        src_sel = 1'b0;
        sw_trig = 1'b0;
        ext_trig = 1'b0;
        failures = 0;
        n_compared = 0;
        slp_e = '{`LPC_SLP_EXP0, `LPC_SLP_EXP1, `LPC_SLP_EXP2,
                  `LPC_SLP_EXP3, `LPC_SLP_EXP4, `LPC_SLP_EXP5,
                  `LPC_SLP_EXP6, `LPC_SLP_EXP7};
        wk_e = '{3, 18, 21, 24};
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        reg_read(16'h006e, d);
        chk8(d, 8'h88);
        tick;
        chk8(reg_rdata, 8'h00);
        reg_read(16'h0123, d);
        chk8(d, 8'h00);
        for (int i = 0; i < 8; i++) begin
            reg_write(16'h006e, 8'h01 << i);
            reg_read(16'h006e, d);
            chk8(d, 8'h01 << i);
        end
        reg_write(16'h006f, 8'hff);
        reg_read(16'h006e, d);
        chk8(d, 8'h80);
        reg_write(16'h006e, 8'h01);
        repeat (20) tick;
        chk8({5'h00, core_sleep, cal_run}, 8'h00);
        // wake settle code kept at 1 or above
        for (int c = 0; c < 8; c++) begin
            timed_cycle({c[2:0], 5'b01001});
        end
        // wake settle codes, code 0 left out
        for (int w = 1; w < 4; w++) begin
            timed_cycle({3'b000, w[1:0], 3'b001});
        end
        trig_cycle(1'b0);
        trig_cycle(1'b1);
        // low power off keeps cores awake
        restart(8'h88);
        repeat (100) tick;
        chk8({5'h00, core_sleep, cal_run}, 8'h01);
        @(posedge sys_clk);
        bg_en <= 1'b0;
        tick;
        tick;
        chk8({5'h00, core_sleep, cal_run}, 8'h00);
        reg_read(16'h006f, d);
        chk8(d, 8'h10);
        print_verdict;
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        print_verdict;
    end
endmodule
